// file: plfcc_pkg.sv
package plfcc_pkg;

    // ==========================================================
    // register map (word offsets as byte addresses)
    // ==========================================================
    localparam logic [3:0] PLFCC_ADDR_CTRL  = 4'h0;   // control bits
    localparam logic [3:0] PLFCC_ADDR_SYN   = 4'h4;   // divider and multiplier
    localparam logic [3:0] PLFCC_ADDR_FLAG  = 4'h8;   // pll flag register
    localparam logic [3:0] PLFCC_ADDR_STAT  = 4'hC;   // live status

    // control register field positions
    localparam int CTRL_PLL_ON    = 0;
    localparam int CTRL_AUTO      = 1;
    localparam int CTRL_ACQ       = 2;
    localparam int CTRL_BUS_CLK_FROM_PLL      = 3;
    localparam int CTRL_MCS       = 4;
    localparam int CTRL_CME       = 5;
    localparam int CTRL_FORCED_MONITOR_ENABLE      = 6;
    localparam int CTRL_NOLH      = 7;
    localparam int CTRL_IN_RANGE_IRQ_ENABLE    = 8;
    localparam int CTRL_FALLBACK_IRQ_ENABLE      = 9;

    // flag register positions
    localparam int FLAG_LOCK      = 0;
    localparam int FLAG_LOCKIF    = 1;
    localparam int FLAG_FALLBACK_ACTIVE_FLAG     = 2;
    localparam int FLAG_FALLBACK_CHANGE_FLAG      = 3;

    // synthesis field widths and reset values
    localparam int          REFDV_W       = 3;
    localparam int          SYN_W         = 6;
    localparam logic [2:0]  REFDV_RST     = 3'h0;
    localparam logic [5:0]  SYN_RST       = 6'h00;
    localparam int          SYN_LSB       = 8;

    // 13-stage counter timing
    localparam int          CNT_W         = 13;
    localparam logic [12:0] CNT_MID       = 13'h1000;   // 4096, mid count

    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // loop filter mode
    typedef enum logic {
        PLFCC_FILT_ACQ,
        PLFCC_FILT_TRK
    } plfcc_filt_e;

    // analog loop status bundle
    typedef struct packed {
        logic in_trk_tol;     // vco within tracking tolerance
        logic out_unt_tol;    // vco outside untracking tolerance
        logic in_lock_tol;    // vco within lock tolerance
        logic out_unl_tol;    // vco outside unlock tolerance
    } plfcc_cmp_s;

    // clock steering outputs
    typedef struct packed {
        logic pll_power_on;
        logic bus_clk_from_pll;
        logic module_clk_select;
        logic monitor_active;
        logic force_pclk;
        logic pll_resume;
    } plfcc_clk_s;

endpackage

// file: plfcc_pll_ctrl.sv
`timescale 1ns/1ps
// Operation
// - divide ref 1..8, multiply 1..64
// - run in wait, suspend stop, resume at once if auto, one cycle later if not
// - lock detect compares feedback against reference
// - acquisition mode reads select bit zero
// - tracking when not acquisition or select set
// - auto mode switches filter by itself
// - auto: select read-only, tolerance set/clear
// - in-range bit read-only with tolerance hysteresis
// - in-range change raises enabled interrupt
// - manual: select writable, chooses filter
// - fallback from vco minimum, needs supply
// - power-up fallback only in normal mode
// - no fallback: monitor reset, latch holds
// - fallback forces power, bus high, module low
// - active flag; change flag with interrupt
// - monitor enabled throughout fallback
// - fallback forces module clocks to pclk
// - poll monitor at count 4096 of 8192
// - clock back: leave, clear, restore selects
// - auto and bus set: pll relocks after
// - reset sets monitor, power, clears disable
// - power-up reset held until count 4096
module plfcc_pll_ctrl
    import plfcc_pkg::*;
#(
    parameter int DIV_MAX = 8,
    parameter int MUL_MAX = 64
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // avalon-mm slave
    input  wire logic [3:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    output logic      [31:0]          o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // pins and analog status (asynchronous)
    input  wire logic                 i_pll_supply,
    input  wire logic                 i_normal_mode,
    input  wire logic                 i_clk_present,
    input  wire plfcc_pkg::plfcc_cmp_s i_cmp,
    input  wire logic                 i_slow_tick,
    input  wire logic                 i_wait_mode,
    input  wire logic                 i_stop_mode,
    // loop and clock control
    output logic [2:0]                o_ref_div,
    output logic [5:0]                o_vco_mul,
    output plfcc_pkg::plfcc_filt_e    o_filt_mode,
    output plfcc_pkg::plfcc_clk_s     o_clk,
    output logic                      o_pll_run,
    // reset and interrupts
    output logic                      o_int_reset_n,
    output logic                      o_monitor_reset,
    output logic                      o_irq
);
    import plfcc_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [9:0]   ctrl;
        logic [2:0]   ref_div;
        logic [5:0]   vco_mul;
        logic         acq_auto;
        logic         lock;
        logic         lock_if;
        logic         lh_active;
        logic         lh_if;
        logic         rst_latch;
        logic         por_done;
        logic         pll_was;
        logic [12:0]  cnt;
        logic [31:0]  rdata;
        logic         ack;
        logic [9:0]   sync1;
        logic [9:0]   sync2;
        logic         stop_was;
    } plfcc_state_s;

    plfcc_state_s state_r;
    plfcc_state_s state_nxt;

    // synchronised inputs
    logic s_supply, s_normal, s_clk_ok, s_tick, s_wait, s_stop;
    plfcc_cmp_s s_cmp;
    assign {s_supply, s_normal, s_clk_ok, s_tick, s_wait, s_stop} = state_r.sync2[9:4];
    assign s_cmp = plfcc_cmp_s'(state_r.sync2[3:0]);

    // raw asynchronous levels into the first synchroniser stage
    logic [9:0] sync_in;
    assign sync_in = {i_pll_supply, i_normal_mode, i_clk_present, i_slow_tick,
                      i_wait_mode, i_stop_mode, i_cmp.in_trk_tol,
                      i_cmp.out_unt_tol, i_cmp.in_lock_tol, i_cmp.out_unl_tol};

    logic auto_bw, acq_bit, mon_en, fb_allowed, clk_lost, mid_hit, access;

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        // two-flop synchroniser, first stage read only here and in the reset branch
        state_nxt.sync1 = sync_in;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.stop_was = s_stop;

        auto_bw    = state_r.ctrl[CTRL_AUTO];
        mon_en     = state_r.ctrl[CTRL_CME] | state_r.ctrl[CTRL_FORCED_MONITOR_ENABLE]
                   | state_r.lh_active;
        fb_allowed = s_supply & ~state_r.ctrl[CTRL_NOLH];
        clk_lost   = mon_en & ~s_clk_ok;
        mid_hit    = s_tick & (state_r.cnt == CNT_MID - 13'h0001);

        // lock detector outcome, hysteresis on tolerances
        if (s_cmp.in_trk_tol)
            state_nxt.acq_auto = 1'b1;
        else if (s_cmp.out_unt_tol)
            state_nxt.acq_auto = 1'b0;
        if (s_cmp.in_lock_tol)
            state_nxt.lock = 1'b1;
        else if (s_cmp.out_unl_tol)
            state_nxt.lock = 1'b0;
        acq_bit = auto_bw ? state_r.acq_auto : state_r.ctrl[CTRL_ACQ];

        // free-running 13-stage counter on slow ticks
        if (s_tick)
            state_nxt.cnt = state_r.cnt + 13'h0001;

        // power-up internal reset held to mid count
        if (!state_r.por_done && mid_hit) begin
            state_nxt.por_done = 1'b1;
            state_nxt.cnt      = '0;
        end

        // fallback entry and exit
        if (!state_r.lh_active && clk_lost && !s_stop) begin
            if (fb_allowed && (state_r.por_done || s_normal)) begin
                state_nxt.lh_active = 1'b1;
                state_nxt.pll_was   = state_r.ctrl[CTRL_BUS_CLK_FROM_PLL];
            end else if (!fb_allowed) begin
                state_nxt.rst_latch = 1'b1;
            end
        end else if (state_r.lh_active && mid_hit && s_clk_ok) begin
            state_nxt.lh_active = 1'b0;
        end
        if (state_r.rst_latch && s_clk_ok)
            state_nxt.rst_latch = 1'b0;

        // bus access, one wait state then acknowledge
        access = (i_avs_read | i_avs_write) & ~state_r.ack;
        state_nxt.ack = access;
        // a write lands on the edge at which waitrequest is low
        if (i_avs_write && state_r.ack) begin
            unique case (i_avs_address)
                PLFCC_ADDR_CTRL: begin
                    state_nxt.ctrl = i_avs_writedata[9:0];
                    if (auto_bw)
                        state_nxt.ctrl[CTRL_ACQ] = state_r.ctrl[CTRL_ACQ];
                end
                PLFCC_ADDR_SYN: begin
                    state_nxt.ref_div = i_avs_writedata[REFDV_W-1:0];
                    state_nxt.vco_mul = i_avs_writedata[SYN_LSB +: SYN_W];
                end
                PLFCC_ADDR_FLAG: begin
                    if (i_avs_writedata[FLAG_LOCKIF])
                        state_nxt.lock_if = 1'b0;
                    if (i_avs_writedata[FLAG_FALLBACK_CHANGE_FLAG])
                        state_nxt.lh_if = 1'b0;
                end
                default: ;
            endcase
        end
        state_nxt.rdata = ZERO_WORD;
        if (access && i_avs_read) begin
            unique case (i_avs_address)
                PLFCC_ADDR_CTRL: begin
                    state_nxt.rdata[9:0] = state_r.ctrl;
                    state_nxt.rdata[CTRL_ACQ] = acq_bit;
                end
                PLFCC_ADDR_SYN: begin
                    state_nxt.rdata[REFDV_W-1:0]    = state_r.ref_div;
                    state_nxt.rdata[SYN_LSB +: SYN_W] = state_r.vco_mul;
                end
                PLFCC_ADDR_FLAG: begin
                    state_nxt.rdata[FLAG_LOCK]   = state_r.lock;
                    state_nxt.rdata[FLAG_LOCKIF] = state_r.lock_if;
                    state_nxt.rdata[FLAG_FALLBACK_ACTIVE_FLAG]  = state_r.lh_active;
                    state_nxt.rdata[FLAG_FALLBACK_CHANGE_FLAG]   = state_r.lh_if;
                end
                PLFCC_ADDR_STAT: begin
                    state_nxt.rdata[3:0] = {state_r.rst_latch, state_r.por_done,
                                            s_clk_ok, s_supply};
                end
                default: ;
            endcase
        end

        // hardware sets win over software clears
        if (state_nxt.lock != state_r.lock)
            state_nxt.lock_if = 1'b1;
        if (state_nxt.lh_active != state_r.lh_active)
            state_nxt.lh_if = 1'b1;

        // reset defaults with supply present
        if (!i_reset_n) begin
            state_nxt = '0;
            state_nxt.ctrl[CTRL_CME]    = 1'b1;
            state_nxt.ctrl[CTRL_PLL_ON] = 1'b1;
            state_nxt.ctrl[CTRL_NOLH]   = 1'b0;
            state_nxt.ctrl[CTRL_AUTO]   = 1'b1;
            state_nxt.ref_div = REFDV_RST;
            state_nxt.vco_mul = SYN_RST;
            // latch survives reset until clock activity is seen again
            state_nxt.rst_latch = state_r.rst_latch & ~s_clk_ok;
            state_nxt.sync1 = sync_in;
            state_nxt.sync2 = state_r.sync1;
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge i_clk) begin
        state_r <= state_nxt;
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign o_ref_div   = state_r.ref_div;
    assign o_vco_mul   = state_r.vco_mul;
    assign o_filt_mode = acq_bit ? PLFCC_FILT_TRK : PLFCC_FILT_ACQ;
    // fallback forcing of clock selects
    assign o_clk.pll_power_on      = state_r.ctrl[CTRL_PLL_ON] | state_r.lh_active;
    assign o_clk.bus_clk_from_pll  = state_r.lh_active ? 1'b1 : state_r.ctrl[CTRL_BUS_CLK_FROM_PLL];
    assign o_clk.module_clk_select = state_r.lh_active ? 1'b0 : state_r.ctrl[CTRL_MCS];
    assign o_clk.monitor_active    = mon_en;
    assign o_clk.force_pclk        = state_r.lh_active;
    assign o_clk.pll_resume        = auto_bw & state_r.pll_was & ~state_r.lh_active;
    // pll runs in wait, suspends in stop, resumes at once with auto, one cycle later without
    assign o_pll_run = o_clk.pll_power_on & ~s_stop
                     & (~state_r.stop_was | s_stop | auto_bw);
    assign o_int_reset_n   = state_r.por_done & ~state_r.rst_latch;
    assign o_monitor_reset = state_r.rst_latch;
    assign o_irq = (state_r.lock_if & state_r.ctrl[CTRL_IN_RANGE_IRQ_ENABLE])
                 | (state_r.lh_if & state_r.ctrl[CTRL_FALLBACK_IRQ_ENABLE]);
    assign o_avs_readdata    = state_r.rdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~state_r.ack;

endmodule

// file: plfcc_properties.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the pll control block
module plfcc_properties
    import plfcc_pkg::*;
(
    // clock, reset and bus
    input wire logic                   i_clk,
    input wire logic                   i_reset_n,
    input wire logic [3:0]             i_avs_address,
    input wire logic                   i_avs_read,
    input wire logic                   i_avs_write,
    input wire logic [31:0]            i_avs_writedata,
    input wire logic                   o_avs_waitrequest,
    // loop and clock control
    input wire logic [2:0]             o_ref_div,
    input wire logic [5:0]             o_vco_mul,
    input wire plfcc_pkg::plfcc_filt_e o_filt_mode,
    input wire plfcc_pkg::plfcc_clk_s  o_clk,
    input wire logic                   o_int_reset_n,
    input wire logic                   o_monitor_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // accepted write to one register
    sequence s_wr(logic [3:0] a);
        i_avs_write && !o_avs_waitrequest && i_avs_address == a;
    endsequence
    sequence s_ctrl_kept;
        s_wr(PLFCC_ADDR_CTRL) ##1 !o_clk.force_pclk;
    endsequence
    property p_ack;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    property p_syn;
        s_wr(PLFCC_ADDR_SYN) |=> o_ref_div == $past(i_avs_writedata[2:0])
            && o_vco_mul == $past(i_avs_writedata[13:8]);
    endproperty
    property p_ctrl;
        s_ctrl_kept |-> o_clk.module_clk_select == $past(i_avs_writedata[4])
            && o_clk.bus_clk_from_pll == $past(i_avs_writedata[3]);
    endproperty
    property p_man;
        s_wr(PLFCC_ADDR_CTRL) ##0 !i_avs_writedata[1] ##1 !o_clk.force_pclk |->
            o_filt_mode == ($past(i_avs_writedata[2]) ? PLFCC_FILT_TRK : PLFCC_FILT_ACQ);
    endproperty
    property p_force;
        o_clk.force_pclk |-> o_clk.pll_power_on && o_clk.bus_clk_from_pll
            && !o_clk.module_clk_select;
    endproperty
    property p_mon;
        o_clk.force_pclk |-> o_clk.monitor_active;
    endproperty
    property p_rst;
        $rose(i_reset_n) |-> o_clk.pll_power_on && o_clk.monitor_active && !o_clk.force_pclk;
    endproperty
    property p_por;
        $rose(i_reset_n) |-> !o_int_reset_n [*8];
    endproperty
    property p_mrst;
        o_monitor_reset |-> !o_clk.force_pclk;
    endproperty
    a_ack:   assert property (p_ack) else $error("request not answered in one cycle");
    a_syn:   assert property (p_syn) else $error("divider or multiplier not updated");
    a_ctrl:  assert property (p_ctrl) else $error("clock selects not from control");
    a_man:   assert property (p_man) else $error("manual filter mode wrong");
    a_force: assert property (p_force) else $error("fallback steering wrong");
    a_mon:   assert property (p_mon) else $error("monitor off in fallback");
    a_rst:   assert property (p_rst) else $error("reset values of power or monitor");
    a_por:   assert property (p_por) else $error("internal reset released early");
    a_mrst:  assert property (p_mrst) else $error("fallback while monitor reset");
endmodule

bind plfcc_pll_ctrl plfcc_properties i_plfcc_properties (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_ref_div(o_ref_div), .o_vco_mul(o_vco_mul),
    .o_filt_mode(o_filt_mode), .o_clk(o_clk), .o_int_reset_n(o_int_reset_n),
    .o_monitor_reset(o_monitor_reset));

// file: plfcc_far.sv
`timescale 1ns/1ps
// ==========================================
// clock source and analog loop model
module plfcc_far
    import plfcc_pkg::*;
(
    // scenario controls
    input  wire logic             i_clk,
    input  wire logic             i_lost,
    input  wire logic             i_trk,
    input  wire logic             i_lock,
    // toward the block
    output logic                  o_clk_present,
    output logic                  o_slow_tick,
    output plfcc_pkg::plfcc_cmp_s o_cmp
);
    // slow clock runs at half rate, one tick every second cycle
    initial o_slow_tick = 1'b0;
    always @(posedge i_clk) o_slow_tick <= ~o_slow_tick;
    // monitor sees the source stop or restart
    assign o_clk_present = !i_lost;
    // comparator levels from feedback against reference, exclusive pairs
    assign o_cmp = '{i_trk, !i_trk, i_lock, !i_lock};
endmodule

// file: plfcc_pll_ctrl_tb.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the pll control block
module plfcc_pll_ctrl_tb;
    import plfcc_pkg::*;
    logic        i_clk = 0, i_reset_n = 0, rd = 0, wr = 0, lost = 0, trk = 0, lock = 0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, o_avs_readdata;
    logic        o_avs_waitrequest, o_int_reset_n, o_monitor_reset, o_irq, present, tick, run;
    logic [2:0]  o_ref_div;
    logic [5:0]  o_vco_mul;
    plfcc_filt_e o_filt_mode;
    plfcc_clk_s  o_clk;
    plfcc_cmp_s  cmp;
    int          error_cnt = 0, tests_run = 0, n;
    always #2.5 i_clk = ~i_clk;
    plfcc_pll_ctrl i_plfcc_pll_ctrl (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_pll_supply(1'b1), .i_normal_mode(1'b1), .i_clk_present(present), .i_cmp(cmp),
        .i_slow_tick(tick), .i_wait_mode(1'b0), .i_stop_mode(1'b0), .o_ref_div(o_ref_div),
        .o_vco_mul(o_vco_mul), .o_filt_mode(o_filt_mode), .o_clk(o_clk), .o_pll_run(run),
        .o_int_reset_n(o_int_reset_n), .o_monitor_reset(o_monitor_reset), .o_irq(o_irq));
    plfcc_far i_plfcc_far (.i_clk(i_clk), .i_lost(lost), .i_trk(trk), .i_lock(lock),
        .o_clk_present(present), .o_slow_tick(tick), .o_cmp(cmp));
    // ==========================================
    // shared tasks
    task close_out;
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a; wdata <= d; rd <= !w; wr <= w; n = 0;
        do begin @(posedge i_clk); n++; end while (o_avs_waitrequest !== 1'b0 && n < 50);
        rdata = o_avs_readdata;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge i_clk); // outputs settle after the accepting edge
        chk(n < 50, 1, "bus answer");
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdata, exp, msg);
    endtask
    task do_reset;
        i_reset_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1; n = 0;
        while (o_int_reset_n !== 1'b1 && n < 20000) begin @(posedge i_clk); n++; end
        chk(n >= 8180 && n < 20000, 1, "internal reset length");
        rd_chk(PLFCC_ADDR_CTRL, 32'h0000_0023, "control reset value");
    endtask
    // ==========================================
    // scenarios
    task t_regs;
        rd_chk(PLFCC_ADDR_SYN, 32'h0000_0000, "synth reset value");
        bus(1'b1, 4'h1, 32'hFFFF_FFFF);
        rd_chk(4'h1, 32'h0000_0000, "unmapped read");
        chk(run, 1, "pll runs outside stop");
    endtask
    task t_syn;
        logic [31:0] v[2];
        v = '{32'h0000_3F07, 32'h0000_0000};
        foreach (v[i]) begin
            bus(1'b1, PLFCC_ADDR_SYN, v[i]);
            chk({o_vco_mul, o_ref_div}, {v[i][13:8], v[i][2:0]}, "divider outputs");
            rd_chk(PLFCC_ADDR_SYN, v[i], "synth readback");
        end
    endtask
    task t_auto;
        trk <= 1'b1; lock <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd_chk(PLFCC_ADDR_CTRL, 32'h0000_0027, "auto select set");
        chk(o_filt_mode, PLFCC_FILT_TRK, "auto tracking");
        rd_chk(PLFCC_ADDR_FLAG, 32'h0000_0003, "in range set");
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_0123);
        chk(o_irq, 1, "in range irq");
        bus(1'b1, PLFCC_ADDR_FLAG, 32'h0000_0002);
        chk({o_irq, rdata[0]}, 0, "in range change cleared");
        trk <= 1'b0; lock <= 1'b0;
        repeat (8) @(posedge i_clk);
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_0127);
        rd_chk(PLFCC_ADDR_CTRL, 32'h0000_0123, "auto select read-only");
        chk(o_filt_mode, PLFCC_FILT_ACQ, "auto acquisition");
        rd_chk(PLFCC_ADDR_FLAG, 32'h0000_0002, "in range cleared");
        chk(o_irq, 1, "out of range irq");
        bus(1'b1, PLFCC_ADDR_FLAG, 32'h0000_0002);
    endtask
    task t_manual;
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_0021);
        chk(o_filt_mode, PLFCC_FILT_ACQ, "manual acquisition");
        repeat (20) @(posedge i_clk);
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_0025);
        rd_chk(PLFCC_ADDR_CTRL, 32'h0000_0025, "manual select writable");
        chk(o_filt_mode, PLFCC_FILT_TRK, "manual tracking");
    endtask
    task t_fallback;
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_023B);
        lost <= 1'b1; n = 0;
        while (o_clk.force_pclk !== 1'b1 && n < 20000) begin @(posedge i_clk); n++; end
        chk({o_clk[5:2], o_clk.force_pclk}, 5'b11011, "fallback steering");
        rd_chk(PLFCC_ADDR_FLAG, 32'h0000_000C, "fallback flags");
        chk(o_irq, 1, "fallback irq");
        bus(1'b1, PLFCC_ADDR_FLAG, 32'h0000_0008);
        lost <= 1'b0; n = 0;
        while (o_clk.force_pclk !== 1'b0 && n < 20000) begin @(posedge i_clk); n++; end
        chk(n < 16420, 1, "poll period");
        chk(o_clk[4:3], 2'b11, "selects restored");
        chk(o_clk.pll_resume, 1, "pll relock after exit");
        rd_chk(PLFCC_ADDR_FLAG, 32'h0000_0008, "fallback left");
        bus(1'b1, PLFCC_ADDR_FLAG, 32'h0000_0008);
    endtask
    task t_nofb;
        bus(1'b1, PLFCC_ADDR_CTRL, 32'h0000_00A1);
        lost <= 1'b1; n = 0;
        while (o_monitor_reset !== 1'b1 && n < 20000) begin @(posedge i_clk); n++; end
        chk({n < 20000, o_clk.force_pclk}, 2'b10, "monitor reset");
        lost <= 1'b0;
        do_reset;
    endtask
    initial begin
        do_reset;
        t_regs;
        t_syn;
        t_auto;
        t_manual;
        t_fallback;
        t_nofb;
        close_out;
    end
    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge i_clk);
        error_cnt++;
        close_out;
    end
endmodule
